// ===== cog_fall_map.svh
`ifndef COG_FALL_MAP_SVH
`define COG_FALL_MAP_SVH

// Register offsets on the plain register port
`define CF_OFS_FALL_EN      4'h0
`define CF_OFS_FALL_MODE    4'h1
`define CF_OFS_SHUT_CTRL    4'h2
`define CF_OFS_SHUT_EN      4'h3
`define CF_OFS_PHASE        4'h4
`define CF_OFS_POLARITY     4'h5
`define CF_OFS_IRQ_STATUS   4'h6
`define CF_OFS_IRQ_MASK     4'h7

// Field positions in the shutdown control and status register
`define CF_SHUT_STATUS_BIT  7
`define CF_AUTO_RESTART_BIT 6
`define CF_BD_HI            5
`define CF_BD_LO            4
`define CF_AC_HI            3
`define CF_AC_LO            2

// Override level codes
`define CF_OVR_ONE          2'h3
`define CF_OVR_ZERO         2'h2
`define CF_OVR_TRISTATE     2'h1
`define CF_OVR_INACTIVE     2'h0

// Interrupt status bits
`define CF_IRQ_FALL_BIT     0
`define CF_IRQ_SHUT_BIT     1
`define CF_IRQ_RESUME_BIT   2

// Reset values
`define CF_RST_BYTE         8'h00
`define CF_RST_PHASE        6'h00

`endif

// ===== cog_fall_pkg.sv
package cog_fall_pkg;

    // Delay engine for edge-triggered falling events
    typedef enum logic {DLY_IDLE, DLY_RUN} dly_state_t;

    // Falling event sources, bit 6 down to bit 0
    typedef struct packed {
        logic third_pwm_output;
        logic second_capture_output;
        logic first_capture_output;
        logic first_logic_cell;
        logic comparator_2;
        logic comparator_1;
        logic mapped_pin;
    } fall_srcs_t;

    // One register port request
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [3:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    // Whole state of the block
    typedef struct packed {
        logic [6:0] fall_src_enable;
        logic [6:0] fall_src_edge_mode;
        logic       auto_restart_enable;
        logic [1:0] override_level_pair_bd;
        logic [1:0] override_level_pair_ac;
        logic [3:0] shut_src_en;
        logic [5:0] falling_phase_delay_count;
        logic [3:0] polarity;
        logic [2:0] irq_status;
        logic [2:0] irq_mask;
        logic       shutdown_status;
        logic       override_on;
        logic [6:0] src_prev;
        dly_state_t dly;
        logic [5:0] dly_cnt;
        logic       fall_evt;
        logic [3:0] out;
        logic [3:0] oe;
        logic [7:0] rdata;
    } state_t;

endpackage : cog_fall_pkg

// ===== cog_fall_shutdown.sv
// Overview of operation
// - Seven enable bits admit listed falling sources
// - Disabled falling source never affects event
// - Edge mode: falling edge, then phase delay
// - Level mode: low level gives immediate event
// - Mode bit ignored while source disabled
// - Shutdown enable upper four bits read zero
// - Status bit reads one while shut down
// - Status reads zero when running or leaving
// - Bit 6 enables automatic restart
// - Bits 5-4 set B and D override
// - Bits 3-2 set A and C override
// - Enabled low second logic cell shuts down
// - Enabled low comparator 2 shuts down
// - Enabled low comparator 1 shuts down
// - Enabled low mapped pin shuts down
// - Disabled shutdown source never causes shutdown
// - Polarity bit set makes active level low
// - Six-bit count sets falling phase delay
//
// Added by the designer: the strobed register port and the address map.
`timescale 1ns/1ps
`include "cog_fall_map.svh"

module cog_fall_shutdown (
    input  wire logic                    mclk_i,             // Generator clock, 100 MHz
    input  wire logic                    reset_n_i,          // Async reset, active low
    input  wire cog_fall_pkg::reg_req_t  reg_i,              // Register port request
    output logic [7:0]                   rdata_o,            // Read data, cycle after read
    input  wire cog_fall_pkg::fall_srcs_t fall_src_i,        // Falling event sources
    input  wire logic                    second_logic_cell_i, // Shutdown-only source
    input  wire logic                    rising_event_i,     // Rising event from selector
    input  wire logic [3:0]              wave_i,             // Raw waveforms D..A
    output logic                         falling_event_o,    // Falling event; one-cycle pulse for edges, held while a level source is low
    output logic                         shutdown_status_o,  // Shutdown state level
    output logic [3:0]                   out_o,              // Output levels D..A
    output logic [3:0]                   out_oe_o,           // Output enables D..A
    output logic                         irq_o               // Level interrupt
);

    logic [1:0]                  rst_sync_r;
    logic                        rst_n;
    cog_fall_pkg::state_t        s_r;
    cog_fall_pkg::state_t        s_nxt;
    logic [6:0]                  src_now;
    logic [6:0]                  lvl_hit;
    logic [6:0]                  edge_hit;
    logic [3:0]                  shut_src;
    logic                        shut_cond;
    logic                        fire;
    logic                        wr_ctrl;

    // Reset is released through two flops so no state leaves reset unevenly
    always_ff @(posedge mclk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            rst_sync_r <= 2'h0;
        else
            rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
    assign rst_n = rst_sync_r[1];

    // Override drive for one output lane: {enable, level}
    function automatic logic [1:0] lane_drive(input logic on, input logic [1:0] code,
                                              input logic pol, input logic wave);
        logic [1:0] r;
        r = {1'b1, wave ^ pol};
        if (on)
        begin
            case (code)
                `CF_OVR_ONE:      r = 2'h3;
                `CF_OVR_ZERO:     r = 2'h2;
                `CF_OVR_TRISTATE: r = 2'h0;
                default:          r = {1'b1, pol};
            endcase
        end
        return r;
    endfunction : lane_drive

    // Register read mux; unimplemented bits and unmapped offsets read zero
    function automatic logic [7:0] read_mux(input cog_fall_pkg::state_t st,
                                            input logic [3:0] a);
        logic [7:0] r;
        r = `CF_RST_BYTE;
        case (a)
            `CF_OFS_FALL_EN:    r = {1'b0, st.fall_src_enable};
            `CF_OFS_FALL_MODE:  r = {1'b0, st.fall_src_edge_mode};
            `CF_OFS_SHUT_CTRL:  r = {st.shutdown_status, st.auto_restart_enable,
                                     st.override_level_pair_bd, st.override_level_pair_ac,
                                     2'h0};
            `CF_OFS_SHUT_EN:    r = {4'h0, st.shut_src_en};
            `CF_OFS_PHASE:      r = {2'h0, st.falling_phase_delay_count};
            `CF_OFS_POLARITY:   r = {4'h0, st.polarity};
            `CF_OFS_IRQ_STATUS: r = {5'h0, st.irq_status};
            `CF_OFS_IRQ_MASK:   r = {5'h0, st.irq_mask};
            default:            r = `CF_RST_BYTE;
        endcase
        return r;
    endfunction : read_mux

    assign src_now  = fall_src_i;
    assign shut_src = {second_logic_cell_i, fall_src_i.comparator_2,
                       fall_src_i.comparator_1, fall_src_i.mapped_pin};

    // Per-source qualification; a cleared enable masks both mode paths
    generate
        for (genvar g = 0; g < 7; g++)
        begin : g_src
            assign lvl_hit[g]  = s_r.fall_src_enable[g] & ~s_r.fall_src_edge_mode[g]
                                 & ~src_now[g];
            assign edge_hit[g] = s_r.fall_src_enable[g] & s_r.fall_src_edge_mode[g]
                                 & s_r.src_prev[g] & ~src_now[g];
        end
    endgenerate

    // Any enabled shutdown source held low forces shutdown
    assign shut_cond = |(s_r.shut_src_en & ~shut_src);
    assign wr_ctrl   = reg_i.wr && (reg_i.addr == `CF_OFS_SHUT_CTRL);

    // Next-state logic for the whole block
    always_comb
    begin
        logic [1:0] drv;
        logic [2:0] ev;
        drv   = 2'h0;
        ev    = 3'h0;
        fire  = 1'b0;
        s_nxt = s_r;
        s_nxt.src_prev = src_now;

        // Register writes
        if (reg_i.wr)
        begin
            case (reg_i.addr)
                `CF_OFS_FALL_EN:   s_nxt.fall_src_enable    = reg_i.wdata[6:0];
                `CF_OFS_FALL_MODE: s_nxt.fall_src_edge_mode = reg_i.wdata[6:0];
                `CF_OFS_SHUT_CTRL:
                begin
                    s_nxt.shutdown_status        = reg_i.wdata[`CF_SHUT_STATUS_BIT];
                    s_nxt.auto_restart_enable    = reg_i.wdata[`CF_AUTO_RESTART_BIT];
                    s_nxt.override_level_pair_bd = reg_i.wdata[`CF_BD_HI:`CF_BD_LO];
                    s_nxt.override_level_pair_ac = reg_i.wdata[`CF_AC_HI:`CF_AC_LO];
                end
                `CF_OFS_SHUT_EN:   s_nxt.shut_src_en = reg_i.wdata[3:0];
                `CF_OFS_PHASE:     s_nxt.falling_phase_delay_count = reg_i.wdata[5:0];
                `CF_OFS_POLARITY:  s_nxt.polarity = reg_i.wdata[3:0];
                `CF_OFS_IRQ_MASK:  s_nxt.irq_mask = reg_i.wdata[2:0];
                default:           s_nxt.irq_mask = s_r.irq_mask;
            endcase
        end

        // Phase delay; edges seen while a delay runs are absorbed by it
        case (s_r.dly)
            cog_fall_pkg::DLY_IDLE:
            begin
                if (|edge_hit)
                begin
                    if (s_r.falling_phase_delay_count == `CF_RST_PHASE)
                        fire = 1'b1;
                    else
                    begin
                        s_nxt.dly     = cog_fall_pkg::DLY_RUN;
                        s_nxt.dly_cnt = s_r.falling_phase_delay_count;
                    end
                end
            end
            cog_fall_pkg::DLY_RUN:
            begin
                if (s_r.dly_cnt == 6'h01)
                begin
                    fire      = 1'b1;
                    s_nxt.dly = cog_fall_pkg::DLY_IDLE;
                end
                else
                    s_nxt.dly_cnt = s_r.dly_cnt - 6'h01;
            end
            default: s_nxt.dly = cog_fall_pkg::DLY_IDLE;
        endcase
        s_nxt.fall_evt = fire | (|lvl_hit);

        // Shutdown status: a live source wins over a software clear
        if (shut_cond)
            s_nxt.shutdown_status = 1'b1;
        else if (s_r.shutdown_status && s_r.auto_restart_enable && !wr_ctrl)
            s_nxt.shutdown_status = 1'b0;

        // Outputs stay overridden until the rising event after status clears
        if (s_nxt.shutdown_status)
            s_nxt.override_on = 1'b1;
        else if (s_r.override_on && rising_event_i)
            s_nxt.override_on = 1'b0;

        for (int i = 0; i < 4; i++)
        begin
            drv = lane_drive(s_nxt.override_on,
                             i[0] ? s_nxt.override_level_pair_bd
                                  : s_nxt.override_level_pair_ac,
                             s_nxt.polarity[i], wave_i[i]);
            s_nxt.oe[i]  = drv[1];
            s_nxt.out[i] = drv[0];
        end

        // Sticky interrupt flags; a new event beats a same-cycle clear
        ev[`CF_IRQ_FALL_BIT]   = s_nxt.fall_evt;
        ev[`CF_IRQ_SHUT_BIT]   = s_nxt.shutdown_status & ~s_r.shutdown_status;
        ev[`CF_IRQ_RESUME_BIT] = s_r.override_on & ~s_nxt.override_on;
        if (reg_i.wr && reg_i.addr == `CF_OFS_IRQ_STATUS)
            s_nxt.irq_status = s_r.irq_status & ~reg_i.wdata[2:0];
        s_nxt.irq_status = s_nxt.irq_status | ev;

        s_nxt.rdata = reg_i.rd ? read_mux(s_r, reg_i.addr) : `CF_RST_BYTE;
    end

    // Single state register
    always_ff @(posedge mclk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_r       <= '0;
            s_r.dly   <= cog_fall_pkg::DLY_IDLE;
            s_r.oe    <= 4'hf;
        end
        else
            s_r <= s_nxt;
    end

    assign rdata_o           = s_r.rdata;
    assign falling_event_o   = s_r.fall_evt;
    assign shutdown_status_o = s_r.shutdown_status;
    assign out_o             = s_r.out;
    assign out_oe_o          = s_r.oe;
    assign irq_o             = |(s_r.irq_status & s_r.irq_mask);

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n);

    // Edge detected with a delay of three, then three run cycles
    sequence edge_start_s;
        s_r.dly == cog_fall_pkg::DLY_IDLE && (|edge_hit) && lvl_hit == 7'h00
        && s_r.falling_phase_delay_count == 6'h03;
    endsequence
    sequence delay_run_s;
        (s_r.dly == cog_fall_pkg::DLY_RUN)[*3];
    endsequence

    chk_edge_phase_delay: assert property (edge_start_s |=> delay_run_s ##1 falling_event_o)
        else $error("edge event not delayed by phase count");
    chk_delay_no_early: assert property (edge_start_s |=> !fire[*2])
        else $error("edge event fired before phase delay");
    chk_level_immediate: assert property ((|lvl_hit) |=> falling_event_o)
        else $error("level event not immediate");
    chk_disabled_silent: assert property (s_r.fall_src_enable == 7'h00
                                          && s_r.dly == cog_fall_pkg::DLY_IDLE
                                          |=> !falling_event_o)
        else $error("disabled sources made a falling event");
    chk_shut_enter: assert property (shut_cond |=> shutdown_status_o && s_r.override_on)
        else $error("enabled low source did not shut down");
    chk_shut_masked: assert property (s_r.shut_src_en == 4'h0 && !s_r.shutdown_status
                                      && !wr_ctrl |=> !shutdown_status_o)
        else $error("disabled source caused shutdown");
    chk_no_auto_restart: assert property (s_r.shutdown_status && !s_r.auto_restart_enable
                                          && !wr_ctrl |=> shutdown_status_o)
        else $error("shutdown left without auto restart");
    chk_auto_restart: assert property (s_r.shutdown_status && s_r.auto_restart_enable
                                       && !shut_cond && !wr_ctrl
                                       |=> !shutdown_status_o)
        else $error("auto restart did not clear status");
    chk_resume_on_rise: assert property (s_r.override_on && !s_r.shutdown_status
                                         && !rising_event_i |=> s_r.override_on)
        else $error("outputs resumed before rising event");
    chk_override_ac_one: assert property (s_r.override_on
                                          && s_r.override_level_pair_ac == `CF_OVR_ONE
                                          |-> out_o[0] && out_oe_o[0] && out_o[2])
        else $error("A/C override one not driven");
    chk_override_bd_float: assert property (s_r.override_on
                                            && s_r.override_level_pair_bd == `CF_OVR_TRISTATE
                                            |-> out_oe_o[1] == 1'b0 && out_oe_o[3] == 1'b0)
        else $error("B/D override not tri-stated");
    chk_inactive_polar: assert property (s_r.override_on
                                         && s_r.override_level_pair_bd == `CF_OVR_INACTIVE
                                         |-> out_o[1] == s_r.polarity[1])
        else $error("inactive level ignores polarity");
    chk_shut_en_upper: assert property (reg_i.rd && reg_i.addr == `CF_OFS_SHUT_EN
                                        |=> rdata_o[7:4] == 4'h0)
        else $error("shutdown enable upper bits not zero");
    chk_status_read: assert property (reg_i.rd && reg_i.addr == `CF_OFS_SHUT_CTRL
                                      |=> rdata_o[7] == $past(s_r.shutdown_status))
        else $error("status bit read wrong");

endmodule : cog_fall_shutdown

// ===== cog_src_model.sv
`timescale 1ns/1ps

module cog_src_model (
    input  wire logic                mclk_i,     // Generator clock
    output cog_fall_pkg::fall_srcs_t fall_src_o, // Falling event sources
    output logic                     cell2_o,    // Second logic cell output
    output logic                     rise_o,     // Rising event from selector
    output logic [3:0]               wave_o      // Raw waveforms D..A
);
    // Sources idle high so no event is pending when reset lifts
    initial
    begin
        fall_src_o = 7'h7f;
        cell2_o = 1'b1;
        rise_o = 1'b0;
        wave_o = 4'h0;
    end

    // Levels move just after an edge, as on-chip logic outputs would
    task automatic put(input logic [7:0] lv, input logic [3:0] wv);
        @(posedge mclk_i);
        fall_src_o <= lv[6:0];
        cell2_o <= lv[7];
        wave_o <= wv;
    endtask : put

    // One-cycle rising event
    task automatic pulse_rise();
        @(posedge mclk_i);
        rise_o <= 1'b1;
        @(posedge mclk_i);
        rise_o <= 1'b0;
    endtask : pulse_rise
endmodule : cog_src_model

// ===== complementary_gen_fall_input_shutdown_tb.sv
`timescale 1ns/1ps

module complementary_gen_fall_input_shutdown_tb;
    logic                     mclk_i;
    logic                     reset_n_i;
    cog_fall_pkg::reg_req_t   req;
    cog_fall_pkg::fall_srcs_t fall_src;
    logic [7:0]               rdata;
    logic                     cell2, rise, fall_evt, shut, irq;
    logic [3:0]               wave, outv, oe, pol, w;
    logic [1:0]               bd, ac;
    logic [7:0]               v, ph;
    logic [15:0]              seed;
    int                       failures, checks_done, n, i, cnt;

    // Free-running generator clock
    initial mclk_i = 1'b0;
    always #5 mclk_i = ~mclk_i;

    cog_fall_shutdown dut_u (
        .mclk_i(mclk_i), .reset_n_i(reset_n_i), .reg_i(req), .rdata_o(rdata),
        .fall_src_i(fall_src), .second_logic_cell_i(cell2), .rising_event_i(rise),
        .wave_i(wave), .falling_event_o(fall_evt), .shutdown_status_o(shut),
        .out_o(outv), .out_oe_o(oe), .irq_o(irq)
    );

    cog_src_model src_u (
        .mclk_i(mclk_i), .fall_src_o(fall_src), .cell2_o(cell2), .rise_o(rise),
        .wave_o(wave)
    );

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr

    // Expected {oe, out}; a tri-stated lane hides its level
    function automatic logic [7:0] exp_out(input logic [1:0] b, input logic [1:0] a,
                                           input logic [3:0] p, input logic [3:0] x,
                                           input logic sd);
        logic [1:0] c;
        logic [7:0] r;
        for (int k = 0; k < 4; k++)
        begin
            c = k[0] ? b : a;
            r[k+4] = !(sd && c == 2'h1);
            r[k] = r[k+4] & (!sd ? (x[k] ^ p[k]) : (c == 2'h0) ? p[k] : c[0]);
        end
        return r;
    endfunction : exp_out

    task automatic check(input string nm, input logic [7:0] e, input logic [7:0] g);
        checks_done++;
        if (g !== e)
        begin
            failures++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : check

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        req <= {2'b10, a, d};
        @(posedge mclk_i);
        req <= '0;
    endtask : wr

    task automatic rdr(input logic [3:0] a, input logic [7:0] e, input string nm);
        @(posedge mclk_i);
        req <= {2'b01, a, 8'h00};
        @(posedge mclk_i);
        req <= '0;
        #1;
        check(nm, e, rdata);
    endtask : rdr

    task automatic settle();
        repeat (2) @(posedge mclk_i);
        #1;
    endtask : settle

    task automatic test_done();
        if (failures == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : test_done

    // Watchdog, far beyond the few hundred cycles the tests need
    initial
    begin
        repeat (30000) @(posedge mclk_i);
        failures++;
        test_done();
    end

    // Main sequence
    initial
    begin
        req = '0;
        reset_n_i = 1'b0;
        seed = 16'd26417;
        failures = 0;
        checks_done = 0;
        repeat (10) @(posedge mclk_i);
        reset_n_i <= 1'b1;
        repeat (3) @(posedge mclk_i);
        for (n = 0; n < 8; n++)
            rdr(n[3:0], 8'h00, "reset value");
        seed = lfsr(seed);
        wr(4'h0, seed[7:0]);
        rdr(4'h0, {1'b0, seed[6:0]}, "fall enable");
        wr(4'h1, seed[15:8]);
        rdr(4'h1, {1'b0, seed[14:8]}, "fall mode");
        wr(4'h2, seed[7:0] & 8'h7f);
        rdr(4'h2, seed[7:0] & 8'h7c, "shutdown ctrl");
        wr(4'h3, 8'hff);
        rdr(4'h3, 8'h0f, "shutdown enable");
        wr(4'h9, 8'hff);
        rdr(4'h9, 8'h00, "unmapped");
        wr(4'h2, 8'h00);
        wr(4'h3, 8'h00);
        // Level mode per source; the others fall with edge mode but stay disabled
        for (n = 0; n < 7; n++)
        begin
            v = 8'h01 << n;
            wr(4'h0, v);
            wr(4'h1, ~v & 8'h7f);
            src_u.put(8'h80 | v, 4'h0);
            settle();
            check("disabled low", 8'h00, fall_evt);
            src_u.put(8'h80, 4'h0);
            settle();
            check("level event", 8'h01, fall_evt);
            src_u.put(8'hff, 4'h0);
            settle();
            check("level released", 8'h00, fall_evt);
        end
        // Edge mode with boundary and random phase counts
        for (n = 0; n < 4; n++)
        begin
            seed = lfsr(seed);
            ph = (n == 0) ? 8'h00 : (n == 1) ? 8'h01 : (n == 2) ? 8'h3f : {2'b00, seed[5:0]};
            i = seed[15:8] % 7;
            v = 8'h01 << i;
            wr(4'h0, v);
            wr(4'h1, v);
            wr(4'h4, ph);
            src_u.put(~v, 4'h0);
            cnt = 0;
            do
            begin
                @(posedge mclk_i);
                #1;
                cnt++;
            end while (fall_evt !== 1'b1 && cnt < 70);
            check("phase delay", ph + 8'h01, 8'(cnt));
            @(posedge mclk_i);
            #1;
            check("edge event width", 8'h00, fall_evt);
            src_u.put(8'hff, 4'h0);
        end
        wr(4'h0, 8'h00);
        wr(4'h6, 8'h07);
        // Each shutdown source, disabled then enabled, every override code
        for (n = 0; n < 4; n++)
        begin
            seed = lfsr(seed);
            bd = n[1:0];
            ac = 2'h3 - n[1:0];
            pol = seed[3:0];
            w = seed[7:4];
            v = 8'h01 << n;
            wr(4'h5, {4'h0, pol});
            wr(4'h2, {2'b00, bd, ac, 2'b00});
            wr(4'h3, ~v & 8'h0f);
            src_u.put((n == 3) ? 8'h7f : ~v, w);
            settle();
            check("disabled source", 8'h00, shut);
            check("running lanes", exp_out(bd, ac, pol, w, 1'b0), {oe, outv & oe});
            wr(4'h3, v);
            settle();
            check("shutdown entry", 8'h01, shut);
            check("override", exp_out(bd, ac, pol, w, 1'b1), {oe, outv & oe});
            rdr(4'h2, {2'b10, bd, ac, 2'b00}, "status bit");
            src_u.put(8'hff, w);
            repeat (3) settle();
            check("no auto restart", 8'h01, shut);
            wr(4'h2, {2'b00, bd, ac, 2'b00});
            settle();
            check("status cleared", 8'h00, shut);
            check("held to rising", exp_out(bd, ac, pol, w, 1'b1), {oe, outv & oe});
            src_u.pulse_rise();
            settle();
            check("resumed", exp_out(bd, ac, pol, w, 1'b0), {oe, outv & oe});
        end
        // Auto restart with the shutdown interrupt masked, unmasked, cleared
        wr(4'h6, 8'h07);
        wr(4'h7, 8'h00);
        wr(4'h3, 8'h01);
        wr(4'h2, 8'h40);
        src_u.put(8'hfe, w);
        settle();
        check("auto shutdown", 8'h01, shut);
        check("irq masked", 8'h00, irq);
        wr(4'h7, 8'h02);
        #1;
        check("irq raised", 8'h01, irq);
        src_u.put(8'hff, w);
        settle();
        check("auto clear", 8'h00, shut);
        check("auto held", exp_out(2'h0, 2'h0, pol, w, 1'b1), {oe, outv & oe});
        src_u.pulse_rise();
        settle();
        check("auto resumed", exp_out(2'h0, 2'h0, pol, w, 1'b0), {oe, outv & oe});
        wr(4'h6, 8'h02);
        #1;
        check("irq cleared", 8'h00, irq);
        test_done();
    end
endmodule : complementary_gen_fall_input_shutdown_tb
